// >>> hdl/rx_tuning_pkg.sv
// constants and carrier types for the receiver tuning register bank
// assumes a byte-wide register port with 7-bit addresses, as on the serial host port
package rx_tuning_pkg;
    // register addresses
    localparam logic [6:0] ADDR_LISTEN_CTRL    = 7'h0E;
    localparam logic [6:0] ADDR_LISTEN_TIMING  = 7'h0D;
    localparam logic [6:0] ADDR_SILICON_REV    = 7'h10;
    localparam logic [6:0] ADDR_FREQ_CORR      = 7'h1F;
    localparam logic [6:0] ADDR_SENSITIVITY    = 7'h58;
    localparam logic [6:0] ADDR_FADING_MARGIN  = 7'h6F;
    localparam logic [6:0] ADDR_LOW_BETA       = 7'h71;
    // field positions
    localparam int LISTEN_ENABLE_BIT   = 6;
    localparam int AUTOCLEAR_BIT       = 3;
    localparam int LOW_BETA_ENABLE_BIT = 5;
    localparam int IDLE_STEP_HI        = 7;
    localparam int IDLE_STEP_LO        = 6;
    localparam int RX_STEP_HI          = 5;
    localparam int RX_STEP_LO          = 4;
    // reset values and setting codes
    localparam logic [7:0] SENS_NORMAL         = 8'h1B;
    localparam logic [7:0] SENS_HIGH           = 8'h2D;
    localparam logic [7:0] FADING_NORMAL       = 8'h00;
    localparam logic [7:0] FADING_LOWBETA_ON   = 8'h10;
    localparam logic [7:0] FADING_LOWBETA_OFF  = 8'h30;
    localparam logic [7:0] LOW_BETA_RESET      = 8'h00;
    localparam logic [7:0] LISTEN_TIMING_RESET = 8'h90;
    localparam logic [7:0] LISTEN_CTRL_RESET   = 8'h00;
    localparam logic [7:0] FREQ_CORR_RESET     = 8'h00;
    localparam logic [1:0] STEP_RESERVED       = 2'h0;
    localparam int unsigned OFFSET_STEP_HZ     = 488;
    // ready indication after reset, counted in sys_clk cycles
    localparam int unsigned READY_DELAY_US     = 10;
    localparam int unsigned CLK_MHZ            = 200;
    localparam int unsigned READY_CYCLES       = READY_DELAY_US * CLK_MHZ;

    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// >>> hdl/rx_tuning_reset_control.sv
// receiver tuning and test register bank with listen-mode steps and reset readiness
// assumes the serial host port is decoded upstream into one-cycle byte requests on sys_clk
// Summary of operation
// - sensitivity boost byte, resets to normal
// - fading margin byte, resets to 0x30
// - low-beta offset times 488 Hz when enabled
// - clock output activity signals ready device
// - idle step field bits 7-6, reset 10
// - rx step field bits 5-4, reset 01
// - clearing listen enable leaves listen mode
// - auto-clear frequency correction during receive
// - read-only revision code at 0x10
`timescale 1ns/100ps
module rx_tuning_reset_control #(
    parameter logic [7:0] REVISION_CODE = 8'h5A  // arbitrary value
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire rx_tuning_pkg::reg_req_t req,
    input  wire logic                    req_valid,
    input  wire logic                    rx_mode_async,
    input  wire logic [7:0]              freq_corr_in,
    input  wire logic                    freq_corr_load,
    output logic [7:0]                   rdata,
    output logic                         rdata_valid,
    output logic [7:0]                   sensitivity_boost_sel,
    output logic [7:0]                   fading_margin_gain_sel,
    output logic [7:0]                   low_beta_offset_val,
    output logic [17:0]                  freq_offset_hz,
    output logic                         listen_active,
    output logic [1:0]                   listen_idle_step,
    output logic [1:0]                   listen_rx_step,
    output logic                         step_unsupported,
    output logic [7:0]                   freq_corr_value,
    output logic                         clock_output
);
    import rx_tuning_pkg::*;

    // state registers and their next values
    logic [7:0]  sens_ff, nxt_sens;
    logic [7:0]  fade_ff, nxt_fade;
    logic [7:0]  beta_ff, nxt_beta;
    logic [7:0]  lctl_ff, nxt_lctl;
    logic [7:0]  ltim_ff, nxt_ltim;
    logic [7:0]  corr_ff, nxt_corr;
    logic [7:0]  rd_ff, nxt_rd;
    logic        rdv_ff, nxt_rdv;
    logic [17:0] offs_ff, nxt_offs;
    logic        unsup_ff, nxt_unsup;
    logic [1:0]  rx_sync_ff, nxt_rx_sync;
    logic [15:0] rdy_cnt_ff, nxt_rdy_cnt;
    logic        ready_ff, nxt_ready;
    logic        clk_out_ff, nxt_clk_out;
    logic        wr_hit;

    // a write is taken on the edge that sees the strobe
    assign wr_hit = req_valid && req.write;

    // register writes; a loaded correction wins over auto-clear so no capture is lost
    // a bus write to the correction register loses to auto-clear in the same cycle
    always_comb begin
        nxt_sens = sens_ff;
        nxt_fade = fade_ff;
        nxt_beta = beta_ff;
        nxt_lctl = lctl_ff;
        nxt_ltim = ltim_ff;
        nxt_corr = corr_ff;
        if (wr_hit) begin
            case (req.addr)
                ADDR_SENSITIVITY:   nxt_sens = req.wdata;
                ADDR_FADING_MARGIN: nxt_fade = req.wdata;
                ADDR_LOW_BETA:      nxt_beta = req.wdata;
                ADDR_LISTEN_CTRL:   nxt_lctl = req.wdata;
                ADDR_LISTEN_TIMING: nxt_ltim = req.wdata;
                ADDR_FREQ_CORR:     nxt_corr = req.wdata;
                default:            nxt_sens = sens_ff;                  // revision and unmapped ignore writes
            endcase
        end
        if (lctl_ff[AUTOCLEAR_BIT] && rx_sync_ff[1]) begin
            nxt_corr = FREQ_CORR_RESET;
        end
        if (freq_corr_load) begin
            nxt_corr = freq_corr_in;
        end
    end

    // read mux; unmapped addresses read zero
    // the answer is registered, so rdata_valid follows the request by one cycle
    always_comb begin
        nxt_rdv = req_valid && !req.write;
        nxt_rd  = 8'h00;
        if (req_valid && !req.write) begin
            case (req.addr)
                ADDR_SENSITIVITY:   nxt_rd = sens_ff;
                ADDR_FADING_MARGIN: nxt_rd = fade_ff;
                ADDR_LOW_BETA:      nxt_rd = beta_ff;
                ADDR_LISTEN_CTRL:   nxt_rd = lctl_ff;
                ADDR_LISTEN_TIMING: nxt_rd = ltim_ff;
                ADDR_FREQ_CORR:     nxt_rd = corr_ff;
                ADDR_SILICON_REV:   nxt_rd = REVISION_CODE;
                default:            nxt_rd = 8'h00;
            endcase
        end
    end

    // derived tuning: offset applies only while low-beta afc is on; steps checked for reserved code
    // the reserved-code flag is advisory; the stored field keeps whatever was written
    always_comb begin
        nxt_offs = 18'h00000;
        if (lctl_ff[LOW_BETA_ENABLE_BIT]) begin
            nxt_offs = 18'(beta_ff * OFFSET_STEP_HZ);
        end
        nxt_unsup = (ltim_ff[IDLE_STEP_HI:IDLE_STEP_LO] == STEP_RESERVED) ||
                    (ltim_ff[RX_STEP_HI:RX_STEP_LO] == STEP_RESERVED);
        nxt_rx_sync = {rx_sync_ff[0], rx_mode_async};
    end

    // ready counter after reset release; clock output toggles only once ready
    // the count is far shorter than the host's millisecond waits, which stay the host's duty
    always_comb begin
        nxt_rdy_cnt = rdy_cnt_ff;
        nxt_ready   = ready_ff;
        nxt_clk_out = 1'b0;
        if (!ready_ff) begin
            nxt_rdy_cnt = rdy_cnt_ff + 16'h0001;
            if (rdy_cnt_ff == 16'(READY_CYCLES - 1)) begin
                nxt_ready = 1'b1;
            end
        end else begin
            nxt_clk_out = !clk_out_ff;
        end
    end

    // tuning, listen and correction registers; reset loads the defaults
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sens_ff    <= SENS_NORMAL;
            fade_ff    <= FADING_LOWBETA_OFF;
            beta_ff    <= LOW_BETA_RESET;
            lctl_ff    <= LISTEN_CTRL_RESET;
            ltim_ff    <= LISTEN_TIMING_RESET;
            corr_ff    <= FREQ_CORR_RESET;
        end else begin
            sens_ff    <= nxt_sens;
            fade_ff    <= nxt_fade;
            beta_ff    <= nxt_beta;
            lctl_ff    <= nxt_lctl;
            ltim_ff    <= nxt_ltim;
            corr_ff    <= nxt_corr;
        end
    end

    // read answer registers; rdata_valid is a one-cycle pulse
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_ff      <= 8'h00;
            rdv_ff     <= 1'b0;
        end else begin
            rd_ff      <= nxt_rd;
            rdv_ff     <= nxt_rdv;
        end
    end

    // derived outputs and receive-mode synchroniser; one cycle behind the settings
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            offs_ff    <= 18'h00000;
            unsup_ff   <= 1'b0;
            rx_sync_ff <= 2'h0;
        end else begin
            offs_ff    <= nxt_offs;
            unsup_ff   <= nxt_unsup;
            rx_sync_ff <= nxt_rx_sync;
        end
    end

    // ready counter and clock output; held silent through reset so the host sees a fresh start
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdy_cnt_ff <= 16'h0000;
            ready_ff   <= 1'b0;
            clk_out_ff <= 1'b0;
        end else begin
            rdy_cnt_ff <= nxt_rdy_cnt;
            ready_ff   <= nxt_ready;
            clk_out_ff <= nxt_clk_out;
        end
    end

    // every output is a flop or a slice of one
    assign rdata                  = rd_ff;
    assign rdata_valid            = rdv_ff;
    assign sensitivity_boost_sel  = sens_ff;
    assign fading_margin_gain_sel = fade_ff;
    assign low_beta_offset_val    = beta_ff;
    assign freq_offset_hz         = offs_ff;
    assign listen_active          = lctl_ff[LISTEN_ENABLE_BIT];
    assign listen_idle_step       = ltim_ff[IDLE_STEP_HI:IDLE_STEP_LO];
    assign listen_rx_step         = ltim_ff[RX_STEP_HI:RX_STEP_LO];
    assign step_unsupported       = unsup_ff;
    assign freq_corr_value        = corr_ff;
    assign clock_output           = clk_out_ff;

    // checks below are off while reset is held, except the reset-value ones
    // write path: every tuning byte lands exactly as written
    AST_SENS_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        wr_hit && req.addr == ADDR_SENSITIVITY |=> sensitivity_boost_sel == $past(req.wdata))
        else $error("sensitivity write not stored");
    AST_FADE_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        wr_hit && req.addr == ADDR_FADING_MARGIN |=> fading_margin_gain_sel == $past(req.wdata))
        else $error("fading margin write not stored");
    AST_BETA_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        wr_hit && req.addr == ADDR_LOW_BETA |=> low_beta_offset_val == $past(req.wdata))
        else $error("low-beta offset write not stored");

    // reset defaults, seen at the first edge after release
    AST_SENS_RESET: assert property (@(posedge sys_clk)
        $fell(reset) |-> sensitivity_boost_sel == SENS_NORMAL)
        else $error("sensitivity reset value wrong");
    AST_FADE_RESET: assert property (@(posedge sys_clk)
        $fell(reset) |-> fading_margin_gain_sel == FADING_LOWBETA_OFF)
        else $error("fading margin reset value wrong");
    AST_BETA_RESET: assert property (@(posedge sys_clk)
        $fell(reset) |-> low_beta_offset_val == LOW_BETA_RESET)
        else $error("low-beta offset reset value wrong");
    AST_IDLE_RESET: assert property (@(posedge sys_clk)
        $fell(reset) |-> listen_idle_step == 2'b10)
        else $error("idle step reset wrong");
    AST_RX_RESET: assert property (@(posedge sys_clk)
        $fell(reset) |-> listen_rx_step == 2'b01)
        else $error("rx step reset wrong");
    AST_LISTEN_RESET: assert property (@(posedge sys_clk)
        $fell(reset) |-> !listen_active)
        else $error("listen mode active after reset");

    // offset follows the previous cycle's enable and offset byte
    AST_OFFSET: assert property (@(posedge sys_clk) disable iff (reset)
        1'b1 |=> freq_offset_hz ==
        ($past(lctl_ff[LOW_BETA_ENABLE_BIT]) ? 18'($past(beta_ff) * OFFSET_STEP_HZ) : 18'h00000))
        else $error("offset not 488 Hz steps");
    AST_OFFSET_OFF: assert property (@(posedge sys_clk) disable iff (reset)
        !lctl_ff[LOW_BETA_ENABLE_BIT] |=> freq_offset_hz == 18'h00000)
        else $error("offset applied while low-beta afc is off");

    // ready indication: silent until the count ends, then a free-running toggle
    AST_READY: assert property (@(posedge sys_clk) disable iff (reset)
        !ready_ff |-> !clock_output)
        else $error("clock output active before ready");
    AST_READY_COUNT: assert property (@(posedge sys_clk) disable iff (reset)
        ready_ff |-> rdy_cnt_ff == 16'(READY_CYCLES))
        else $error("ready raised at the wrong count");
    AST_READY_TOGGLE: assert property (@(posedge sys_clk) disable iff (reset)
        ready_ff |=> clock_output != $past(clock_output))
        else $error("clock output not toggling once ready");

    // listen timing fields and listen enable
    AST_IDLE_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        wr_hit && req.addr == ADDR_LISTEN_TIMING |=> listen_idle_step == $past(req.wdata[7:6]))
        else $error("idle step write not stored");
    AST_RX_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        wr_hit && req.addr == ADDR_LISTEN_TIMING |=> listen_rx_step == $past(req.wdata[5:4]))
        else $error("rx step write not stored");
    AST_LISTEN_ENTER: assert property (@(posedge sys_clk) disable iff (reset)
        wr_hit && req.addr == ADDR_LISTEN_CTRL && req.wdata[6] |=> listen_active)
        else $error("listen mode not entered");
    AST_LISTEN_EXIT: assert property (@(posedge sys_clk) disable iff (reset)
        wr_hit && req.addr == ADDR_LISTEN_CTRL && !req.wdata[6] |=> !listen_active)
        else $error("listen mode not left");
    AST_LISTEN_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
        !(wr_hit && req.addr == ADDR_LISTEN_CTRL) |=> listen_active == $past(listen_active))
        else $error("listen mode changed without a write");

    // frequency correction: load wins, auto-clear in receive, held unless a bus write hits it
    AST_AUTOCLEAR: assert property (@(posedge sys_clk) disable iff (reset)
        lctl_ff[AUTOCLEAR_BIT] && rx_sync_ff[1] && !freq_corr_load |=> freq_corr_value == 8'h00)
        else $error("correction not auto-cleared");
    AST_CORR_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
        freq_corr_load |=> freq_corr_value == $past(freq_corr_in))
        else $error("loaded correction lost");
    AST_CORR_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
        !(lctl_ff[AUTOCLEAR_BIT] && rx_sync_ff[1]) && !freq_corr_load &&
        !(wr_hit && req.addr == ADDR_FREQ_CORR) |=> $stable(freq_corr_value))
        else $error("correction changed outside auto-clear");

    // revision code is read-only and every read answers once
    AST_REVISION: assert property (@(posedge sys_clk) disable iff (reset)
        req_valid && !req.write && req.addr == 7'h10 |=> rdata_valid && rdata == REVISION_CODE)
        else $error("revision read wrong");
    AST_REV_NOWRITE: assert property (@(posedge sys_clk) disable iff (reset)
        wr_hit && req.addr == ADDR_SILICON_REV |=> $stable({sens_ff, fade_ff, beta_ff, lctl_ff, ltim_ff}))
        else $error("write to revision code changed a setting");
    AST_READ_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
        1'b1 |=> rdata_valid == ($past(req_valid) && !$past(req.write)))
        else $error("read answer strobe wrong");

    // reserved step codes raise the unsupported flag, legal ones clear it
    AST_RESERVED: assert property (@(posedge sys_clk) disable iff (reset)
        listen_idle_step == STEP_RESERVED |=> step_unsupported)
        else $error("reserved step not flagged");
    AST_RX_RESERVED: assert property (@(posedge sys_clk) disable iff (reset)
        listen_rx_step == STEP_RESERVED |=> step_unsupported)
        else $error("reserved rx step not flagged");
    AST_UNSUP_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
        listen_idle_step != STEP_RESERVED && listen_rx_step != STEP_RESERVED |=> !step_unsupported)
        else $error("legal steps flagged unsupported");
endmodule

// >>> tb/rx_tuning_reset_control_tb.sv
// self-checking bench for the receiver tuning register bank
// assumes the host model above drives all register traffic
`timescale 1ns/100ps
module rx_tuning_reset_control_tb;
    import rx_tuning_pkg::*;
    localparam logic [7:0] REV = 8'h5A; // arbitrary revision value
    typedef struct packed { logic [6:0] a; logic [7:0] d; logic [7:0] e; } row_t;
    logic        sys_clk = 1'b0, reset = 1'b1, rx_mode_async = 1'b0, freq_corr_load = 1'b0;
    logic [7:0]  freq_corr_in = 8'h00, rdata, sens, fade, lowb, fcv, v;
    logic [17:0] offs;
    logic [1:0]  idle_s, rx_s;
    logic        rdata_valid, req_valid, active, unsup, clock_output, ok;
    reg_req_t    req;
    int          n_fail = 0, checked = 0;
    // writes and read-backs: every documented code, read-only and unmapped places
    row_t rows[11] = '{'{7'h58, 8'h2D, 8'h2D}, '{7'h58, 8'h1B, 8'h1B}, '{7'h6F, 8'h00, 8'h00},
                       '{7'h6F, 8'h10, 8'h10}, '{7'h6F, 8'h30, 8'h30}, '{7'h71, 8'hFF, 8'hFF},
                       '{7'h0D, 8'h50, 8'h50}, '{7'h0D, 8'hF0, 8'hF0}, '{7'h10, 8'h00, REV},
                       '{7'h1F, 8'h3C, 8'h3C}, '{7'h7F, 8'hAA, 8'h00}};
    always #2.5 sys_clk = ~sys_clk;
    rx_tuning_reset_control #(.REVISION_CODE(REV)) u_dut (.sys_clk(sys_clk), .reset(reset), .req(req),
        .req_valid(req_valid), .rx_mode_async(rx_mode_async), .freq_corr_in(freq_corr_in),
        .freq_corr_load(freq_corr_load), .rdata(rdata), .rdata_valid(rdata_valid),
        .sensitivity_boost_sel(sens), .fading_margin_gain_sel(fade), .low_beta_offset_val(lowb),
        .freq_offset_hz(offs), .listen_active(active), .listen_idle_step(idle_s), .listen_rx_step(rx_s),
        .step_unsupported(unsup), .freq_corr_value(fcv), .clock_output(clock_output));
    spi_host_model u_host (.sys_clk(sys_clk), .rdata(rdata), .rdata_valid(rdata_valid),
        .clock_output(clock_output), .req(req), .req_valid(req_valid));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic results;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog sized well beyond the ready delay plus all traffic
    initial begin
        #150000;
        n_fail++;
        $display("watchdog expired");
        results();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        u_host.wait_ready(ok);
        chk(ok, 1, "ready");
        foreach (rows[i]) begin
            u_host.wr(rows[i].a, rows[i].d);
            u_host.rd(rows[i].a, v);
            chk(v, rows[i].e, "readback");
        end
        chk({sens, fade, lowb}, {SENS_NORMAL, FADING_LOWBETA_OFF, 8'hFF}, "table outputs");
        $display("register table test done");
        // independent step fields and listen exit by a plain enable clear
        u_host.wr(ADDR_LISTEN_TIMING, 8'h60);
        u_host.wr(ADDR_LISTEN_CTRL, 8'h40);
        settle(2);
        chk(idle_s, 2'h1, "idle step");
        chk(rx_s, 2'h2, "rx step");
        chk({active, unsup}, 2'h2, "listen on");
        u_host.wr(ADDR_LISTEN_CTRL, 8'h00);
        u_host.wr(ADDR_LISTEN_TIMING, 8'h30);
        settle(2);
        chk({active, unsup}, 2'h1, "listen off, idle reserved");
        u_host.wr(ADDR_LISTEN_TIMING, 8'hC0);
        settle(2);
        chk(unsup, 1, "rx reserved");
        $display("listen test done");
        // offset only while low-beta is enabled, at the top code
        u_host.wr(ADDR_LOW_BETA, 8'hFF);
        u_host.wr(ADDR_LISTEN_CTRL, 8'h20);
        settle(2);
        chk(offs, 18'(8'hFF * OFFSET_STEP_HZ), "offset on");
        u_host.wr(ADDR_LISTEN_CTRL, 8'h00);
        settle(2);
        chk(offs, 18'h00000, "offset off");
        // correction holds outside receive, clears itself inside it
        u_host.wr(ADDR_LISTEN_CTRL, 8'h08);
        @(posedge sys_clk);
        freq_corr_in   <= 8'h5C;
        freq_corr_load <= 1'b1;
        @(posedge sys_clk);
        freq_corr_load <= 1'b0;
        settle(4);
        chk(fcv, 8'h5C, "corr held");
        rx_mode_async <= 1'b1;
        settle(6);
        chk(fcv, 8'h00, "corr cleared");
        rx_mode_async <= 1'b0;
        $display("offset and correction test done");
        // mid-run reset brings every setting back and silences the ready clock
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        chk({sens, fade, lowb}, {SENS_NORMAL, FADING_LOWBETA_OFF, LOW_BETA_RESET}, "reset bytes");
        chk({idle_s, rx_s, active, clock_output}, 6'h24, "reset listen");
        $display("reset test done");
        results();
    end
endmodule

// >>> tb/spi_host_model.sv
// behavioural host that reaches the tuning register bank one byte request at a time
// assumes requests are taken at the rising sys_clk edge that sees req_valid high
`timescale 1ns/100ps
module spi_host_model
    import rx_tuning_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic [7:0]              rdata,
    input  wire logic                    rdata_valid,
    input  wire logic                    clock_output,
    output rx_tuning_pkg::reg_req_t      req,
    output logic                         req_valid
);
    initial begin
        req       = '{1'b0, 7'h7F, 8'hFF};
        req_valid = 1'b0;
    end
    // waiting for clock output activity replaces the fixed post-reset waits
    task automatic wait_ready(output logic ok);
        int n;
        n = 0;
        do @(posedge sys_clk); while (clock_output !== 1'b1 && ++n < 3000);
        ok = (clock_output === 1'b1);
    endtask
    // one write; the released bus shows inverted data so stale values never look valid
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req       <= '{1'b1, a, d};
        req_valid <= 1'b1;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        req       <= '{1'b0, ~a, ~d};
    endtask
    // one read; answer waited for under a short bound
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        req       <= '{1'b0, a, 8'hA5};
        req_valid <= 1'b1;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        req       <= '{1'b1, ~a, 8'h5A};
        do @(posedge sys_clk); while (rdata_valid !== 1'b1 && ++n < 8);
        d = (rdata_valid === 1'b1) ? rdata : 'x;
    endtask
endmodule
